// *** src/chan_cfg_if.sv ***
// carrier between the register file and the per-channel decoder
`timescale 1ns/1ps
`default_nettype none
interface chan_cfg_if;
    logic [15:0] vcmp;
    logic [15:0] cur;
    logic [11:0] code;
    logic [1:0]  vpd;
    logic        ipd;
    logic        int_ref_on;
    logic        cmp_raw;
    modport src (output vcmp, cur, code, vpd, ipd, int_ref_on, cmp_raw);
    modport dst (input  vcmp, cur, code, vpd, ipd, int_ref_on, cmp_raw);
endinterface : chan_cfg_if
`default_nettype wire

// *** src/chan_decode.sv ***
// per-channel decoder: reference, gain, mode, code and comparator pin
`timescale 1ns/1ps
`default_nettype none
module chan_decode #(
    parameter int CODE_W = 12
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    chan_cfg_if.dst                     cfg,
    output logic [1:0]                  ref_src_r,
    output logic [2:0]                  stage_gain_r,
    output logic                        vout_on_r,
    output logic                        iout_on_r,
    output logic [3:0]                  cur_range_r,
    output logic [CODE_W-1:0]           vcode_r,
    output logic [7:0]                  icode_r,
    output logic                        cmp_active_r,
    output logic [1:0]                  cmp_type_r,
    output logic                        fb_hiz_r,
    output logic                        pin_out_r,
    output logic                        pin_oe_r
);
    wire [2:0] gsel     = cfg.vcmp[dac_cfg_pkg::VC_GAIN_LSB +: 3];
    wire       cmp_en   = cfg.vcmp[dac_cfg_pkg::VC_EN_BIT];
    wire       pin_en   = cfg.vcmp[dac_cfg_pkg::VC_PIN_EN_BIT];
    wire       drain    = cfg.vcmp[dac_cfg_pkg::VC_DRAIN_BIT];
    wire       inv      = cfg.vcmp[dac_cfg_pkg::VC_INV_BIT];
    wire       hiz_dis  = cfg.vcmp[dac_cfg_pkg::VC_HIZ_DIS_BIT];
    // external used unless the supply code is picked, or internal is on and an internal gain is picked
    wire       sel_vdd  = (gsel == dac_cfg_pkg::GAIN_VDD);
    // spare codes 6 and 7 fall into the 4x gain
    wire       sel_intg = (gsel >= dac_cfg_pkg::GAIN_1P5);
    wire       use_int  = cfg.int_ref_on && sel_intg;
    wire [1:0] ref_nxt  = sel_vdd ? dac_cfg_pkg::REF_VDD :
                          use_int ? dac_cfg_pkg::REF_INT : dac_cfg_pkg::REF_EXT;
    logic [2:0] gain_nxt;
    always_comb begin
        gain_nxt = dac_cfg_pkg::STG_G1;
        if (use_int) begin
            unique case (gsel)
                dac_cfg_pkg::GAIN_1P5: gain_nxt = dac_cfg_pkg::STG_G1P5;
                dac_cfg_pkg::GAIN_2:   gain_nxt = dac_cfg_pkg::STG_G2;
                dac_cfg_pkg::GAIN_3:   gain_nxt = dac_cfg_pkg::STG_G3;
                default:               gain_nxt = dac_cfg_pkg::STG_G4;
            endcase
        end
    end
    wire vout_nxt  = (cfg.vpd == 2'h0);
    wire iout_nxt  = !cfg.ipd && (cfg.vpd == dac_cfg_pkg::VPD_HIZ);
    // comparator needs voltage mode
    wire act_nxt   = cmp_en && vout_nxt;
    wire [7:0] ic_nxt = cfg.cur[dac_cfg_pkg::CS_CODE_SEL_BIT] ?
                        cfg.cur[dac_cfg_pkg::CS_BYTE_LSB +: 8] :
                        cfg.code[11:4];
    wire lvl       = cfg.cmp_raw ^ inv;
    // open drain only pulls low; push-pull drives both levels
    wire oe_nxt    = act_nxt && pin_en && (!drain || !lvl);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ref_src_r    <= dac_cfg_pkg::REF_EXT;
            stage_gain_r <= dac_cfg_pkg::STG_G1;
            vout_on_r    <= 1'b0;
            iout_on_r    <= 1'b0;
            cur_range_r  <= 4'h0;
            vcode_r      <= '0;
            icode_r      <= 8'h00;
            cmp_active_r <= 1'b0;
            cmp_type_r   <= dac_cfg_pkg::CMP_PLAIN;
            fb_hiz_r     <= 1'b1;
            pin_out_r    <= 1'b0;
            pin_oe_r     <= 1'b0;
        end else begin
            ref_src_r    <= ref_nxt;
            stage_gain_r <= gain_nxt;
            vout_on_r    <= vout_nxt;
            iout_on_r    <= iout_nxt;
            cur_range_r  <= cfg.cur[dac_cfg_pkg::CS_RANGE_LSB +: 4];
            vcode_r      <= cfg.code[11 -: CODE_W];
            icode_r      <= ic_nxt;
            cmp_active_r <= act_nxt;
            cmp_type_r   <= cfg.vcmp[dac_cfg_pkg::VC_TYPE_LSB +: 2];
            fb_hiz_r     <= !hiz_dis;
            pin_out_r    <= lvl && !drain;
            pin_oe_r     <= oe_nxt;
        end
    end
    a_ext_gain_unity: assert property (@(posedge core_clk) disable iff (rst)
        (ref_nxt != dac_cfg_pkg::REF_INT) |=> stage_gain_r == dac_cfg_pkg::STG_G1)
        else $error("gain not unity without internal reference");
    a_vdd_ref_sel: assert property (@(posedge core_clk) disable iff (rst)
        sel_vdd |=> ref_src_r == dac_cfg_pkg::REF_VDD && stage_gain_r == dac_cfg_pkg::STG_G1)
        else $error("supply reference not unity");
    a_int_ref_gate: assert property (@(posedge core_clk) disable iff (rst)
        !cfg.int_ref_on |=> ref_src_r != dac_cfg_pkg::REF_INT)
        else $error("internal reference used while off");
    a_int_gain_map: assert property (@(posedge core_clk) disable iff (rst)
        (use_int && gsel == dac_cfg_pkg::GAIN_3) |=> stage_gain_r == dac_cfg_pkg::STG_G3)
        else $error("internal gain 3 misdecoded");
    a_cmp_pin_off: assert property (@(posedge core_clk) disable iff (rst)
        (!cmp_en || !pin_en) |=> !pin_oe_r)
        else $error("comparator pin driven while off");
    a_drain_no_high: assert property (@(posedge core_clk) disable iff (rst)
        (act_nxt && pin_en && drain) |=> !pin_out_r && (pin_oe_r == !$past(lvl)))
        else $error("open drain drove high");
    a_fb_hiz_ctl: assert property (@(posedge core_clk) disable iff (rst)
        $rose(hiz_dis) |=> !fb_hiz_r)
        else $error("feedback stayed high impedance");
    a_iout_mode: assert property (@(posedge core_clk) disable iff (rst)
        iout_on_r |-> !vout_on_r && !cmp_active_r)
        else $error("current mode overlaps voltage mode");
    c_cmp_drive: cover property (@(posedge core_clk) disable iff (rst) pin_oe_r);
    c_int_ref: cover property (@(posedge core_clk) disable iff (rst)
        ref_src_r == dac_cfg_pkg::REF_INT);
    c_iout: cover property (@(posedge core_clk) disable iff (rst) iout_on_r);
endmodule : chan_decode
`default_nettype wire

// *** src/dac_cfg_pkg.sv ***
// constants and types for the quad channel output configuration block
// Operation
// - internal reference disabled after reset
// - writing one enables internal reference
// - internal reference gains 1.5, 2, 3, 4
// - voltage code 10 or 12 bits wide
// - external reference is default after reset
// - gain field code also selects external reference
// - external reference forces unity gain
// - supply reference forces unity gain
// - current range field selects output range
// - current mode uses 8-bit code
// - compare enable puts channel into comparator; here only while the voltage output is on (vpd 00)
// - pin: disabled, none, push-pull/open-drain, inverted
// - feedback high impedance until disable written
// - per-channel compare type selects operation
// - compare type 00 plain 01 hyst 10 window
package dac_cfg_pkg;
    localparam int NUM_CHAN = 4;
    localparam int ADDR_W   = 4;
    // register offsets
    localparam logic [3:0] OFS_COMMON    = 4'h0;
    localparam logic [3:0] OFS_DEVMODE   = 4'h1;
    localparam logic [3:0] OFS_STATUS    = 4'h2;
    localparam logic [3:0] OFS_VCMP_BASE = 4'h4; // 4..7 per channel
    localparam logic [3:0] OFS_CUR_BASE  = 4'h8; // 8..b per channel
    localparam logic [3:0] OFS_DATA_BASE = 4'hc; // c..f per channel
    // common register fields
    localparam int COM_INT_REF_BIT  = 0;
    localparam int COM_VPD_LSB      = 8;  // 2 bits per channel
    localparam int COM_IPD_LSB      = 4;  // 1 bit per channel
    localparam int DEV_IN_DIS_BIT   = 0;
    // voltage compare register fields
    localparam int VC_GAIN_LSB      = 0;  // 3 bits
    localparam int VC_EN_BIT        = 3;
    localparam int VC_PIN_EN_BIT    = 4;
    localparam int VC_DRAIN_BIT     = 5;
    localparam int VC_INV_BIT       = 6;
    localparam int VC_HIZ_DIS_BIT   = 7;
    localparam int VC_TYPE_LSB      = 8;  // 2 bits
    // current setup register fields
    localparam int CS_RANGE_LSB     = 0;  // 4 bits
    localparam int CS_CODE_SEL_BIT  = 4;
    localparam int CS_BYTE_LSB      = 8;  // 8 bits
    // reset values
    localparam logic [15:0] COMMON_RST = 16'hfff0; // all powered down, hi-z
    localparam logic [15:0] DEVMODE_RST = 16'h0000;
    localparam logic [15:0] VCMP_RST   = 16'h0000;
    localparam logic [15:0] CUR_RST    = 16'h0000;
    localparam logic [1:0]  VPD_HIZ    = 2'h3;
    typedef enum logic [2:0] {
        GAIN_EXT  = 3'h0, GAIN_VDD = 3'h1, GAIN_1P5 = 3'h2,
        GAIN_2    = 3'h3, GAIN_3   = 3'h4, GAIN_4   = 3'h5
    } gain_sel_t;
    typedef enum logic [1:0] {
        CMP_PLAIN = 2'h0, CMP_HYST = 2'h1, CMP_WINDOW = 2'h2, CMP_INVALID = 2'h3
    } cmp_type_t;
    typedef enum logic [1:0] {
        REF_EXT = 2'h0, REF_INT = 2'h1, REF_VDD = 2'h2
    } ref_src_t;
    typedef enum logic [2:0] {
        STG_G1 = 3'h0, STG_G1P5 = 3'h1, STG_G2 = 3'h2, STG_G3 = 3'h3, STG_G4 = 3'h4
    } stage_gain_t;
endpackage : dac_cfg_pkg

// *** src/dac_chan_config.sv ***
// top: register file and four channel decoders
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dac_chan_config #(
    parameter int CODE_W = 12
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [15:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [15:0]                 reg_rdata,
    input  wire logic [3:0]                  cmp_raw,
    output logic      [3:0]                  output_pin_out,
    output logic      [3:0]                  output_pin_oe,
    output logic      [3:0]                  feedback_pin_hiz,
    output logic      [3:0]                  vout_on,
    output logic      [3:0]                  iout_on,
    output logic      [3:0]                  cmp_active,
    output logic      [7:0]                  cmp_type,
    output logic      [7:0]                  ref_src,
    output logic      [11:0]                 stage_gain,
    output logic      [15:0]                 cur_range,
    output logic      [4*CODE_W-1:0]         vcode,
    output logic      [31:0]                 icode,
    output logic                             int_ref_on,
    output logic                             input_mode_disable
);
    logic [15:0] common_r;
    logic [15:0] devmode_r;
    logic [15:0] vcmp_r [4];
    logic [15:0] cur_r  [4];
    logic [11:0] code_r [4];
    logic [15:0] status_r;

    wire        hit_common = reg_addr == dac_cfg_pkg::OFS_COMMON;
    wire        hit_dev    = reg_addr == dac_cfg_pkg::OFS_DEVMODE;
    wire        hit_stat   = reg_addr == dac_cfg_pkg::OFS_STATUS;
    wire [1:0]  ch         = reg_addr[1:0];
    wire        hit_vcmp   = reg_addr[3:2] == dac_cfg_pkg::OFS_VCMP_BASE[3:2];
    wire        hit_cur    = reg_addr[3:2] == dac_cfg_pkg::OFS_CUR_BASE[3:2];
    wire        hit_data   = reg_addr[3:2] == dac_cfg_pkg::OFS_DATA_BASE[3:2];
    // unmapped offset 3 reads zero
    wire [15:0] rd_mux = hit_common ? common_r :
                         hit_dev    ? devmode_r :
                         hit_stat   ? status_r :
                         hit_vcmp   ? vcmp_r[ch] :
                         hit_cur    ? cur_r[ch] :
                         hit_data   ? {4'h0, code_r[ch]} : 16'h0000;
    // narrow variant keeps the code left aligned in 12 bits
    wire [11:0] code_wr = reg_wdata[11:0] & ~12'((1 << (12 - CODE_W)) - 1);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            common_r  <= dac_cfg_pkg::COMMON_RST;
            devmode_r <= dac_cfg_pkg::DEVMODE_RST;
            reg_rdata <= 16'h0000;
        end else begin
            if (reg_wr && hit_common)
                common_r <= reg_wdata;
            if (reg_wr && hit_dev)
                devmode_r <= reg_wdata;
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    genvar g;
    generate
        for (g = 0; g < dac_cfg_pkg::NUM_CHAN; g++) begin : g_chan
            chan_cfg_if cif ();
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    vcmp_r[g] <= dac_cfg_pkg::VCMP_RST;
                    cur_r[g]  <= dac_cfg_pkg::CUR_RST;
                    code_r[g] <= 12'h000;
                end else if (reg_wr && ch == 2'(g)) begin
                    if (hit_vcmp)
                        vcmp_r[g] <= reg_wdata;
                    if (hit_cur)
                        cur_r[g] <= reg_wdata;
                    if (hit_data)
                        code_r[g] <= code_wr;
                end
            end
            assign cif.vcmp       = vcmp_r[g];
            assign cif.cur        = cur_r[g];
            assign cif.code       = code_r[g];
            assign cif.vpd        = common_r[dac_cfg_pkg::COM_VPD_LSB + 2*g +: 2];
            assign cif.ipd        = common_r[dac_cfg_pkg::COM_IPD_LSB + g];
            assign cif.int_ref_on = common_r[dac_cfg_pkg::COM_INT_REF_BIT];
            assign cif.cmp_raw    = cmp_raw[g];
            chan_decode #(.CODE_W(CODE_W)) u_dec (
                .core_clk     (core_clk),
                .rst          (rst),
                .cfg          (cif.dst),
                .ref_src_r    (ref_src[2*g +: 2]),
                .stage_gain_r (stage_gain[3*g +: 3]),
                .vout_on_r    (vout_on[g]),
                .iout_on_r    (iout_on[g]),
                .cur_range_r  (cur_range[4*g +: 4]),
                .vcode_r      (vcode[CODE_W*g +: CODE_W]),
                .icode_r      (icode[8*g +: 8]),
                .cmp_active_r (cmp_active[g]),
                .cmp_type_r   (cmp_type[2*g +: 2]),
                .fb_hiz_r     (feedback_pin_hiz[g]),
                .pin_out_r    (output_pin_out[g]),
                .pin_oe_r     (output_pin_oe[g])
            );
        end
    endgenerate

    // status shows decoded channel modes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_r           <= 16'h0000;
            int_ref_on         <= 1'b0;
            input_mode_disable <= 1'b0;
        end else begin
            status_r           <= {4'h0, cmp_active, iout_on, vout_on};
            int_ref_on         <= common_r[dac_cfg_pkg::COM_INT_REF_BIT];
            input_mode_disable <= devmode_r[dac_cfg_pkg::DEV_IN_DIS_BIT];
        end
    end

    a_rd_zero_idle: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_int_ref_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_common && reg_wdata[0]) |=> ##1 int_ref_on)
        else $error("internal reference did not enable");
    a_chan_isolated: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_vcmp && ch == 2'h0) |=> $stable(vcmp_r[1]))
        else $error("write leaked to another channel");
    c_wr_rd: cover property (@(posedge core_clk) disable iff (rst) reg_wr ##1 reg_rd);
endmodule : dac_chan_config
`default_nettype wire

// *** testbench/dac_chan_config_tb_top.sv ***
// self-checking bench for the quad channel output configuration block
`timescale 1ns/1ps
`default_nettype none
module dac_chan_config_tb_top;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr   = 1'b0;
    logic        reg_rd   = 1'b0;
    logic [3:0]  cmp_raw  = 4'h0;
    logic [15:0] reg_rdata;
    logic [3:0]  output_pin_out, output_pin_oe, feedback_pin_hiz, vout_on, iout_on, cmp_active;
    logic [7:0]  cmp_type, ref_src;
    logic [11:0] stage_gain;
    logic [15:0] cur_range;
    logic [47:0] vcode;
    logic [31:0] icode;
    logic        int_ref_on, input_mode_disable;
    logic        rd_d     = 1'b0;
    logic        probe    = 1'b0;
    logic [2:0]  probe_sel = 3'h0;
    logic [31:0] obs;
    logic [31:0] exp_q[$];
    logic [31:0] seed     = 32'h7820;
    logic [15:0] com_m    = dac_cfg_pkg::COMMON_RST;
    logic        dm_m     = 1'b0;
    logic [15:0] vc_m[4]  = '{default: 16'h0000};
    logic [15:0] cs_m[4]  = '{default: 16'h0000};
    logic [15:0] cd_m[4]  = '{default: 16'h0000};
    logic [3:0]  raw_m    = 4'h0;
    int          failures = 0;
    int          checked  = 0;

    dac_chan_config #(.CODE_W(12)) DUT (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
        .output_pin_out(output_pin_out), .output_pin_oe(output_pin_oe),
        .feedback_pin_hiz(feedback_pin_hiz), .vout_on(vout_on), .iout_on(iout_on),
        .cmp_active(cmp_active), .cmp_type(cmp_type), .ref_src(ref_src),
        .stage_gain(stage_gain), .cur_range(cur_range), .vcode(vcode), .icode(icode),
        .int_ref_on(int_ref_on), .input_mode_disable(input_mode_disable)
    );

    always #10 core_clk = ~core_clk;

    always_comb begin
        case (probe_sel)
            3'h0:    obs = {16'h0000, output_pin_oe, output_pin_out, feedback_pin_hiz, cmp_active};
            3'h1:    obs = {12'h000, iout_on, vout_on, 2'h0, int_ref_on, input_mode_disable,
                            cmp_type};
            3'h2:    obs = {12'h000, ref_src, stage_gain};
            3'h3:    obs = icode;
            3'h4:    obs = {cur_range, 4'h0, vcode[11:0]};
            default: obs = vcode[47:16];
        endcase
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            failures++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp

    // read data stand only in the cycle after the strobe, so compare exactly there
    always @(posedge core_clk) begin
        if (rd_d) cmp(exp_q.pop_front(), {16'h0000, reg_rdata});
        if (probe) cmp(exp_q.pop_front(), obs);
        rd_d <= reg_rd;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd   <= 1'b0;
    endtask : rd

    task automatic prb(input logic [2:0] s, input logic [31:0] e);
        @(posedge core_clk);
        probe_sel <= s;
        probe     <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk);
        probe     <= 1'b0;
    endtask : prb

    task automatic wrm(input logic [3:0] a, input logic [15:0] d);
        if (a == 4'h0) com_m = d;
        else if (a == 4'h1) dm_m = d[0];
        else if (a[3:2] == 2'h1) vc_m[a[1:0]] = d;
        else if (a[3:2] == 2'h2) cs_m[a[1:0]] = d;
        else if (a[3:2] == 2'h3) cd_m[a[1:0]] = d;
        wr(a, d);
    endtask : wrm

    task automatic check_all();
        logic [3:0]  von, ion, act, po, oe, hiz;
        logic [7:0]  ty, rs;
        logic [11:0] sg;
        logic [31:0] ic;
        logic [15:0] cr;
        logic [47:0] vc;
        logic        lvl;
        logic [2:0]  g;
        for (int i = 0; i < 4; i++) begin
            von[i] = (com_m[8+2*i +: 2] == 2'h0);
            ion[i] = !com_m[4+i] && (com_m[8+2*i +: 2] == 2'h3);
            act[i] = vc_m[i][3] && von[i];
            lvl    = raw_m[i] ^ vc_m[i][6];
            // push-pull level follows the comparator even while the pin is released; open drain holds it low
            po[i]  = lvl && !vc_m[i][5];
            oe[i]  = act[i] && vc_m[i][4] && (!vc_m[i][5] || !lvl);
            hiz[i] = !vc_m[i][7];
            ty[2*i +: 2] = vc_m[i][9:8];
            g = vc_m[i][2:0];
            rs[2*i +: 2] = (g == 3'h1) ? 2'h2 : ((g >= 3'h2 && com_m[0]) ? 2'h1 : 2'h0);
            sg[3*i +: 3] = (g < 3'h2 || !com_m[0]) ? 3'h0 : ((g >= 3'h5) ? 3'h4 : g - 3'h1);
            ic[8*i +: 8] = cs_m[i][4] ? cs_m[i][15:8] : cd_m[i][11:4];
            cr[4*i +: 4] = cs_m[i][3:0];
            vc[12*i +: 12] = cd_m[i][11:0];
        end
        repeat (2) @(posedge core_clk);
        prb(3'h0, {16'h0000, oe, po, hiz, act});
        prb(3'h1, {12'h000, ion, von, 2'h0, com_m[0], dm_m, ty});
        prb(3'h2, {12'h000, rs, sg});
        prb(3'h3, ic);
        prb(3'h4, {cr, 4'h0, vc[11:0]});
        prb(3'h5, vc[47:16]);
        rd(dac_cfg_pkg::OFS_STATUS, {20'h00000, act, ion, von});
    endtask : check_all

    task automatic stop_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    initial begin
        #(20 * 20000);
        failures++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        logic [1:0]  c;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(dac_cfg_pkg::OFS_COMMON, {16'h0000, dac_cfg_pkg::COMMON_RST});
        check_all();
        wr(4'h3, 16'h5a5a);
        rd(4'h3, 32'h0); // unmapped place stays empty
        wr(dac_cfg_pkg::OFS_STATUS, 16'hffff);
        wrm(dac_cfg_pkg::OFS_DEVMODE, 16'h0001);
        wrm(dac_cfg_pkg::OFS_CUR_BASE, 16'h0000);
        wrm(dac_cfg_pkg::OFS_COMMON, 16'h00f1);
        check_all();
        // first half keeps every voltage output on so the comparator path is reached
        for (int n = 0; n < 24; n++) begin
            r = rnd();
            c = r[25:24];
            wrm(dac_cfg_pkg::OFS_COMMON, (n < 12) ? {8'h00, r[7:0]} : r[15:0]);
            wrm(dac_cfg_pkg::OFS_VCMP_BASE + 4'(c), {6'h00, r[9:0]});
            r = rnd();
            wrm(dac_cfg_pkg::OFS_CUR_BASE + 4'(c), {r[15:8], 3'h0, r[4:0]});
            wrm(dac_cfg_pkg::OFS_DATA_BASE + 4'(c), {4'h0, r[27:16]});
            @(posedge core_clk);
            cmp_raw <= r[31:28];
            raw_m = r[31:28];
            check_all();
        end
        for (int g = 0; g < 8; g++) begin
            wrm(dac_cfg_pkg::OFS_COMMON, {15'h0000, g[0]});
            wrm(dac_cfg_pkg::OFS_VCMP_BASE + 4'(g[1:0]), {8'h00, 5'h01, 3'(g)});
            check_all();
        end
        stop_test();
    end
endmodule : dac_chan_config_tb_top
`default_nettype wire
